// ### rais_top.sv
// reset and interrupt sequencer with an axi4-lite register slave
// Functional notes
// - reset aborts insn, vector fffe, clock div4
// - pin low long enough causes external reset
// - internal reset: pin 32, hold 32 more
// - power-on: 4096 hold, pin +32, cpu +64
// - power-on sets power and supply flags only
// - low supply: pin low, then power-on timing
// - watchdog overflow resets, sets watchdog flag
// - any write to ffff clears watchdog
// - unknown opcode resets, sets bad opcode flag
// - halt without permit counts as bad opcode
// - opcode fetch unmapped resets, sets address flag
// - data access unmapped never resets
// - cause register read-only, read clears all
// - flags of several resets accumulate
// - pin sampled after release, low sets pin flag
// - forced monitor entry sets monitor flag
// - interrupts wait for instruction end
// - entry stacks, masks, loads vector; return unstacks
// - latched interrupt cannot be preempted
// - unmasked: highest priority pending served first
// - pending at return served before next insn
// - index high byte never stacked
// - mask blocks all but trap; 0 highest
`include "rais_defines.svh"
`default_nettype none
module rais_top #(
	parameter int NSRC = 20,
	parameter int WDOG_W = 18,
	parameter int STAB_CYC = `RAIS_STAB_CYC
) (
	input wire logic aclk, // reference clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [7:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [7:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire logic por_req, // power-on detector, async
	input wire logic low_supply, // supply below rising trip, async
	input wire logic rst_pin_in, // reset pin level, async
	output logic rst_pin_out, // reset pin drive level
	output logic rst_pin_oe, // reset pin pull-down enable
	input wire logic cpu_fetch, // opcode fetch strobe
	input wire logic cpu_unmapped, // current address unmapped
	input wire logic cpu_bad_op, // fetched opcode not in set
	input wire logic cpu_halt_op, // fetched opcode is halt
	input wire logic cpu_wr, // cpu write strobe
	input wire logic [15:0] cpu_addr, // cpu address
	input wire logic monitor_force, // forced monitor mode entry
	output logic cpu_reset, // cpu held in reset, aborts insn
	output logic clk_hold, // cpu and module clocks stopped
	output logic bus_clk_div4, // bus clock is reference div 4
	output logic [15:0] reset_vec, // reset vector location
	input wire logic insn_done, // current instruction finished
	input wire logic soft_trap_insn, // finished insn was the trap
	input wire logic return_from_interrupt, // return insn begins
	input wire logic cpu_cli, // software clears the mask
	input wire logic [NSRC-1:0] irq_req, // requests, bit k priority k+1
	output logic int_busy, // entry or return in progress
	output logic stk_push, // push one byte
	output logic stk_pop, // pop one byte
	output rais_pkg::rais_stkb_t stk_byte, // 0 pcl 1 pch 2 x 3 a 4 ccr
	output logic vec_load, // load pc from vec_addr
	output logic [15:0] vec_addr, // vector location
	output logic imask // global interrupt mask
);
	import rais_pkg::*;
	localparam int SW = $clog2(NSRC + 1);
	localparam int TRL = `RAIS_T_RL_CYC;

	typedef struct packed {
		logic [1:0] s_por;
		logic [1:0] s_ls;
		logic [1:0] s_pin;
		rais_rst_e rst_st;
		logic [12:0] cnt;
		logic [7:0] flags;
		logic [WDOG_W-1:0] wdog;
		logic halt_ok;
		logic fast;
		logic cpu_reset;
		logic pin_oe;
		logic clk_hold;
		rais_int_e int_st;
		rais_stkb_t ibyte;
		logic [SW-1:0] src;
		logic imask;
		logic stk_push;
		logic stk_pop;
		logic vec_load;
		logic [15:0] vec_addr;
		logic busy;
		logic div4;
		logic aw_ok;
		logic [7:0] aw_a;
		logic w_ok;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rais_state_s;

	rais_state_s r;
	rais_state_s n;
	logic rd_cause;

	// register index: 0 cause, 1 control, 2 status, 3 unmapped
	function automatic logic [1:0] rais_idx(input logic [7:0] a);
		unique case (a)
			`RAIS_OFF_CAUSE: rais_idx = 2'h0;
			`RAIS_OFF_CTRL: rais_idx = 2'h1;
			`RAIS_OFF_STAT: rais_idx = 2'h2;
			default: rais_idx = 2'h3;
		endcase
	endfunction : rais_idx

	// lowest set bit gives the winner, returned as priority number
	function automatic logic [SW-1:0] rais_first(input logic [NSRC-1:0] v);
		rais_first = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				rais_first = SW'(i + 1);
			end
		end
	endfunction : rais_first

	assign rd_cause = r.arready && arvalid && rais_idx(araddr) == 2'h0;

	always_comb begin
		logic run;
		logic [7:0] set_f;
		logic [7:0] clr_f;
		logic wd_clr;
		run = 1'b0;
		set_f = '0;
		clr_f = '0;
		wd_clr = 1'b0;
		n = r;
		// the first stage of each chain feeds only the second
		n.s_por = {r.s_por[0], por_req};
		n.s_ls = {r.s_ls[0], low_supply};
		n.s_pin = {r.s_pin[0], rst_pin_in};
		run = r.rst_st == R_RUN && !r.cpu_reset;

		// watchdog counts only while the cpu runs
		wd_clr = cpu_wr && cpu_addr == `RAIS_WDOG_ADDR;
		if (r.cpu_reset || wd_clr) begin
			n.wdog = '0;
		end else begin
			n.wdog = r.wdog + 1'b1;
		end

		// internal sources; data accesses are not looked at at all
		set_f[`RAIS_B_WDOG] = run && (&r.wdog);
		set_f[`RAIS_B_BADOP] = run && cpu_fetch &&
			(cpu_bad_op || (cpu_halt_op && !r.halt_ok));
		set_f[`RAIS_B_BADAD] = run && cpu_fetch && cpu_unmapped;
		set_f[`RAIS_B_MON] = run && monitor_force;

		// reset sequencer
		unique case (r.rst_st)
			R_RUN: begin
				n.cnt = '0;
				if (|set_f) begin
					n.rst_st = R_DRIVE;
				end else if (!r.s_pin[1]) begin
					n.rst_st = R_EXT;
				end
			end
			R_EXT: begin
				// pin held low by the outside; a short glitch is ignored
				if (r.cnt != 13'(TRL - 1)) begin
					n.cnt = r.cnt + 13'd1;
				end
				if (n.cnt == 13'(TRL - 1) && r.cnt != 13'(TRL - 1)) begin
					set_f[`RAIS_B_PIN] = 1'b1;
				end
				if (r.s_pin[1]) begin
					n.rst_st = R_RUN;
				end
			end
			R_STAB: begin
				n.cnt = r.cnt + 13'd1;
				if (r.cnt == 13'(STAB_CYC - 1)) begin
					n.rst_st = R_DRIVE;
					n.cnt = '0;
				end
			end
			R_LSLOW: begin
				n.cnt = '0;
				if (!r.s_ls[1]) begin
					n.rst_st = R_STAB;
				end
			end
			R_DRIVE: begin
				n.cnt = r.cnt + 13'd1;
				if (r.cnt == 13'(`RAIS_REL_CYC - 1)) begin
					// pin was released 32 cycles ago; still low means outside hold
					set_f[`RAIS_B_PIN] = !r.s_pin[1];
					n.rst_st = R_RUN;
					n.cnt = '0;
				end
			end
			default: begin
				n.rst_st = R_STAB;
				n.cnt = '0;
			end
		endcase
		if (r.s_ls[1] && r.rst_st != R_LSLOW) begin
			n.rst_st = R_LSLOW;
			n.cnt = '0;
			set_f[`RAIS_B_LS] = 1'b1;
		end

		// status flags: a set in the same cycle as the read-clear wins
		if (rd_cause) begin
			clr_f = r.flags;
		end
		n.flags = (r.flags & ~clr_f) | set_f;
		n.flags[0] = 1'b0;
		if (r.s_por[1]) begin
			n.rst_st = R_STAB;
			n.cnt = '0;
			n.flags = `RAIS_CAUSE_RST;
		end

		// pin, clock and cpu controls follow the next state
		n.pin_oe = n.rst_st == R_STAB || n.rst_st == R_LSLOW ||
			(n.rst_st == R_DRIVE && n.cnt < 13'(`RAIS_PIN_CYC));
		n.clk_hold = n.rst_st == R_STAB || n.rst_st == R_LSLOW;
		n.cpu_reset = n.rst_st != R_RUN &&
			!(n.rst_st == R_EXT && n.cnt != 13'(TRL - 1));
		if (n.cpu_reset) begin
			n.fast = 1'b0;
		end

		// interrupt entry and return, only between instructions
		n.vec_load = 1'b0;
		if (r.cpu_reset) begin
			n.int_st = I_IDLE;
			n.imask = 1'b1;
			n.ibyte = '0;
		end else begin
			unique case (r.int_st)
				I_IDLE: begin
					n.ibyte = '0;
					if (return_from_interrupt) begin
						n.int_st = I_UNSTK;
						// a stack gives back its bytes last one first
						n.ibyte = 3'(`RAIS_STACK_BYTES - 1);
					end else if (insn_done && soft_trap_insn) begin
						n.int_st = I_STACK;
						n.src = '0;
					end else if (insn_done && !r.imask && |irq_req) begin
						n.int_st = I_STACK;
						n.src = rais_first(irq_req);
					end else if (cpu_cli) begin
						n.imask = 1'b0;
					end
				end
				I_STACK: begin
					// requests are not looked at until the vector is loaded
					n.ibyte = r.ibyte + 3'd1;
					if (r.ibyte == 3'(`RAIS_STACK_BYTES - 1)) begin
						n.int_st = I_VEC;
						n.imask = 1'b1;
						n.vec_addr = `RAIS_VEC_TRAP - 16'({r.src, 1'b0});
					end
				end
				I_VEC: begin
					n.int_st = I_IDLE;
				end
				I_UNSTK: begin
					n.ibyte = r.ibyte - 3'd1;
					if (r.ibyte == 3'h0) begin
						n.imask = 1'b0;
						n.ibyte = '0;
						n.int_st = I_IDLE;
						if (|irq_req) begin
							n.int_st = I_STACK;
							n.src = rais_first(irq_req);
						end
					end
				end
				default: begin
					n.int_st = I_IDLE;
				end
			endcase
		end
		n.stk_push = n.int_st == I_STACK;
		n.stk_pop = n.int_st == I_UNSTK;
		n.vec_load = n.int_st == I_VEC;
		n.busy = n.int_st != I_IDLE;

		// bus write: address and data taken in either order
		if (r.awready && awvalid) begin
			n.aw_ok = 1'b1;
			n.aw_a = awaddr;
		end
		if (r.wready && wvalid) begin
			n.w_ok = 1'b1;
			n.w_d = wdata;
			n.w_s = wstrb;
		end
		if (r.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_ok && r.w_ok && !r.bvalid) begin
			n.aw_ok = 1'b0;
			n.w_ok = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `RAIS_RESP_OKAY;
			unique case (rais_idx(r.aw_a))
				2'h1: begin
					if (r.w_s[0]) begin
						n.halt_ok = r.w_d[`RAIS_CTRL_HALT];
						n.fast = r.w_d[`RAIS_CTRL_FAST];
					end
				end
				2'h3: n.bresp = `RAIS_RESP_SLVERR;
				default: n.bresp = `RAIS_RESP_OKAY; // cause and status ignore writes
			endcase
		end
		n.awready = !n.aw_ok;
		n.wready = !n.w_ok;
		n.div4 = !n.fast;

		// bus read: one outstanding, answer one cycle after the address
		if (r.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (r.arready && arvalid) begin
			n.rvalid = 1'b1;
			n.rresp = `RAIS_RESP_OKAY;
			unique case (rais_idx(araddr))
				2'h0: n.rdata = {24'h0, r.flags};
				2'h1: n.rdata = {30'h0, r.fast, r.halt_ok};
				2'h2: n.rdata = {22'h0, r.imask, r.int_st, r.rst_st};
				default: begin
					n.rdata = '0;
					n.rresp = `RAIS_RESP_SLVERR;
				end
			endcase
		end
		n.arready = !n.rvalid;
	end

	// power-up looks like a power-on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.rst_st <= R_STAB;
			r.int_st <= I_IDLE;
			r.flags <= `RAIS_CAUSE_RST;
			r.cpu_reset <= 1'b1;
			r.pin_oe <= 1'b1;
			r.clk_hold <= 1'b1;
			r.imask <= 1'b1;
			r.div4 <= 1'b1;
			r.arready <= 1'b1;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign awready = r.awready;
	assign wready = r.wready;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign arready = r.arready;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign rst_pin_out = 1'b0; // open drain: only the enable moves
	assign rst_pin_oe = r.pin_oe;
	assign cpu_reset = r.cpu_reset;
	assign clk_hold = r.clk_hold;
	assign bus_clk_div4 = r.div4;
	assign reset_vec = `RAIS_VEC_RESET;
	assign int_busy = r.busy;
	assign stk_push = r.stk_push;
	assign stk_pop = r.stk_pop;
	assign stk_byte = r.ibyte;
	assign vec_load = r.vec_load;
	assign vec_addr = r.vec_addr;
	assign imask = r.imask;

	default clocking rais_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence push_all;
		stk_push [*5];
	endsequence
	sequence load_vec;
		vec_load && imask && !stk_push;
	endsequence

	pin_drive_a: assert property (r.rst_st == R_DRIVE && r.cnt < 13'd32 |-> rst_pin_oe)
		else $error("reset pin not driven in first 32 cycles");
	cpu_release_a: assert property (
		r.rst_st == R_DRIVE && r.cnt == 13'd63 && !r.s_por[1] && !r.s_ls[1]
		|=> !cpu_reset && !rst_pin_oe)
		else $error("cpu not released after 64 cycles");
	stab_end_a: assert property (
		r.rst_st == R_STAB && r.cnt == 13'(STAB_CYC - 1) && !r.s_por[1] && !r.s_ls[1]
		|=> !clk_hold && rst_pin_oe && cpu_reset)
		else $error("stabilisation end wrong");
	por_flags_a: assert property (r.s_por[1] |=> r.flags == 8'h82)
		else $error("power-on flags wrong");
	read_clear_a: assert property (
		|($past(r.flags) & ~r.flags) |-> $past(rd_cause) || $past(r.s_por[1]))
		else $error("flag cleared without read");
	flag_keep_a: assert property (
		!rd_cause && !r.s_por[1] |=> (r.flags & $past(r.flags)) == $past(r.flags))
		else $error("flags did not accumulate");
	wdog_clear_a: assert property (cpu_wr && cpu_addr == 16'hffff |=> r.wdog == '0)
		else $error("watchdog not cleared");
	halt_reset_a: assert property (
		!cpu_reset && r.rst_st == R_RUN && cpu_fetch && cpu_halt_op && !r.halt_ok
		&& !r.s_por[1] && !r.s_ls[1] |=> cpu_reset && r.flags[4])
		else $error("halt without permit not reset");
	mask_block_a: assert property (
		!cpu_reset && r.int_st == I_IDLE && insn_done && imask && !soft_trap_insn
		&& !return_from_interrupt |=> !stk_push)
		else $error("masked request taken");
	entry_order_a: assert property (@(posedge aclk) disable iff (!aresetn || cpu_reset)
		$rose(stk_push) |-> push_all ##1 load_vec)
		else $error("entry sequence broken");
endmodule : rais_top
`default_nettype wire

// ### rais_defines.svh
// register offsets, field positions, reset values and timing counts of the sequencer
`ifndef RAIS_DEFINES_SVH
`define RAIS_DEFINES_SVH
`define RAIS_OFF_CAUSE 8'h00
`define RAIS_OFF_CTRL 8'h04
`define RAIS_OFF_STAT 8'h08
`define RAIS_CAUSE_RST 8'h82
`define RAIS_B_POR 7
`define RAIS_B_PIN 6
`define RAIS_B_WDOG 5
`define RAIS_B_BADOP 4
`define RAIS_B_BADAD 3
`define RAIS_B_MON 2
`define RAIS_B_LS 1
`define RAIS_CTRL_HALT 0
`define RAIS_CTRL_FAST 1
`define RAIS_STAB_CYC 4096
`define RAIS_PIN_CYC 32
`define RAIS_REL_CYC 64
`define RAIS_REF_NS 5
`define RAIS_T_RL_NS 100
`define RAIS_T_RL_CYC ((`RAIS_T_RL_NS + `RAIS_REF_NS - 1) / `RAIS_REF_NS)
`define RAIS_STACK_BYTES 5
`define RAIS_VEC_RESET 16'hfffe
`define RAIS_VEC_TRAP 16'hfffc
`define RAIS_WDOG_ADDR 16'hffff
`define RAIS_RESP_OKAY 2'h0
`define RAIS_RESP_SLVERR 2'h2
`endif

// ### rais_pkg.sv
// types shared by the reset and interrupt sequencer
`default_nettype none
package rais_pkg;
	typedef enum logic [4:0] {
		R_RUN = 5'h01,
		R_STAB = 5'h02,
		R_LSLOW = 5'h04,
		R_DRIVE = 5'h08,
		R_EXT = 5'h10
	} rais_rst_e;
	typedef enum logic [3:0] {
		I_IDLE = 4'h1,
		I_STACK = 4'h2,
		I_VEC = 4'h4,
		I_UNSTK = 4'h8
	} rais_int_e;
	typedef logic [2:0] rais_stkb_t;
endpackage : rais_pkg
`default_nettype wire

// ### rais_far_model.sv
// far-side model: reset pin with pull-up, an outside holder and a slow release
`default_nettype none
module rais_far_model (
	input wire logic aclk, // reference clock
	input wire logic rst_pin_oe, // device pulls the pin low
	input wire logic ext_low, // outside circuit holds the pin low
	input wire logic [7:0] lag, // cycles the outside keeps it low after release
	output logic rst_pin_in // pin level seen by the device
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lag_cnt = 8'h00;
	// a slow outside circuit keeps the pin low after the device lets go;
	// loading while driven keeps the pin from popping high at the hand-over
	always @(posedge aclk) begin
		if (rst_pin_oe) lag_cnt <= lag;
		else if (lag_cnt != 8'h00) lag_cnt <= lag_cnt - 8'h01;
	end
	// open drain with pull-up: high unless some party pulls it down
	assign rst_pin_in = !(rst_pin_oe || ext_low || lag_cnt != 8'h00);
endmodule : rais_far_model
`default_nettype wire

// ### tb.sv
// self-checking testbench of the reset and interrupt sequencer
`default_nettype none
module tb;
	import rais_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STAB = 16;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [15:0] cpu_addr = 16'hffff;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, lag = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, dd;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, rst_pin_in, rst_pin_out, rst_pin_oe;
	logic [1:0] bresp, rresp, r;
	logic por_req = 1'h0, low_supply = 1'h0, ext_low = 1'h0, monitor_force = 1'h0;
	logic cpu_fetch = 1'h0, cpu_unmapped = 1'h0, cpu_bad_op = 1'h0, cpu_halt_op = 1'h0;
	logic cpu_wr = 1'h0, insn_done = 1'h0, soft_trap = 1'h0, rfi = 1'h0, cpu_cli = 1'h0;
	logic cpu_reset, clk_hold, bus_clk_div4, int_busy, stk_push, stk_pop, vec_load, imask;
	logic [15:0] reset_vec, vec_addr;
	logic [19:0] irq_req = 20'h0;
	rais_stkb_t stk_byte;
	int failures = 0, n_checks = 0, cyc = 0, rises = 0, base;
	int oe_c = 0, rs_c = 0, hd_c = 0, oe_len = 0, rs_len = 0, hd_len = 0;

	rais_top #(.WDOG_W(8), .STAB_CYC(STAB)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .por_req, .low_supply, .rst_pin_in,
		.rst_pin_out, .rst_pin_oe, .cpu_fetch, .cpu_unmapped, .cpu_bad_op, .cpu_halt_op,
		.cpu_wr, .cpu_addr, .monitor_force, .cpu_reset, .clk_hold, .bus_clk_div4,
		.reset_vec, .insn_done, .soft_trap_insn(soft_trap), .return_from_interrupt(rfi),
		.cpu_cli, .irq_req, .int_busy, .stk_push, .stk_pop, .stk_byte, .vec_load, .vec_addr,
		.imask);
	rais_far_model far (.aclk, .rst_pin_oe, .ext_low, .lag, .rst_pin_in);

	initial begin
		forever #2.5 aclk = ~aclk;
	end
	// run lengths of the reset outputs; software writes to cpu_addr every 16 cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		cpu_wr <= cyc[3:0] == 4'h0;
		oe_c <= (aresetn && rst_pin_oe === 1'h1) ? oe_c + 1 : 0;
		rs_c <= (aresetn && cpu_reset === 1'h1) ? rs_c + 1 : 0;
		hd_c <= (aresetn && clk_hold === 1'h1) ? hd_c + 1 : 0;
		if (rst_pin_oe === 1'h0 && oe_c != 0) oe_len <= oe_c;
		if (cpu_reset === 1'h0 && rs_c != 0) rs_len <= rs_c;
		if (clk_hold === 1'h0 && hd_c != 0) hd_len <= hd_c;
		if (aresetn && cpu_reset === 1'h1 && rs_c == 0) rises <= rises + 1;
	end

	task give_verdict();
		if (failures == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task cmp(input string w, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask : cmp
	// counts taken from a free-running monitor may be one edge off at either end
	task cmp_near(input string w, input int e, input int g);
		n_checks++;
		if (g < e - 1 || g > e + 1) begin
			failures++;
			$display("wrong value %s expected %0d seen %0d", w, e, g);
		end
	endtask : cmp_near
	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic av, wv;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		av = 1'h1;
		wv = 1'h1;
		while (av || wv) begin
			@(posedge aclk);
			if (av && awready === 1'h1) begin
				av = 1'h0;
				awvalid <= 1'h0;
			end
			if (wv && wready === 1'h1) begin
				wv = 1'h0;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		rs = bresp;
		bready <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask : rd
	task chk(input string w, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] rs;
		rd(a, d, rs);
		cmp(w, e, d);
	endtask : chk
	// waits for a reset to start (if one comes) and for the cpu to be let go
	task wait_rst();
		int n;
		n = 0;
		while (cpu_reset !== 1'h1 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		while (cpu_reset === 1'h1 && n < 9000) begin
			@(posedge aclk);
			n++;
		end
		cmp("cpu release", 32'h0, {31'h0, cpu_reset});
		tick(4);
	endtask : wait_rst
	task fetch(input logic bad, input logic halt, input logic unm);
		@(posedge aclk);
		cpu_fetch <= 1'h1;
		cpu_bad_op <= bad;
		cpu_halt_op <= halt;
		cpu_unmapped <= unm;
		@(posedge aclk);
		cpu_fetch <= 1'h0;
		cpu_unmapped <= 1'h0;
	endtask : fetch
	task insn(input logic trap);
		@(posedge aclk);
		insn_done <= 1'h1;
		soft_trap <= trap;
		@(posedge aclk);
		insn_done <= 1'h0;
		soft_trap <= 1'h0;
	endtask : insn
	task ret();
		@(posedge aclk);
		rfi <= 1'h1;
		@(posedge aclk);
		rfi <= 1'h0;
	endtask : ret
	// counts stack traffic and vector loads; inj offers a trap in mid-entry
	task watch(input logic inj, input logic [15:0] v, input int pops, input int pushes);
		int np, nq, nv;
		logic [15:0] got;
		np = 0;
		nq = 0;
		nv = 0;
		got = 16'h0;
		for (int i = 0; i < 24; i++) begin
			@(posedge aclk);
			insn_done <= inj && i == 2;
			soft_trap <= inj && i == 2;
			if (stk_push === 1'h1) begin
				cmp("pushed byte", np, {29'h0, stk_byte});
				np++;
			end
			if (stk_pop === 1'h1) begin
				cmp("popped byte", 4 - nq, {29'h0, stk_byte});
				nq++;
			end
			if (vec_load === 1'h1) begin
				nv++;
				got = vec_addr;
			end
		end
		cmp("pops", pops, nq);
		cmp("pushes", pushes, np);
		cmp("vector loads", pushes / 5, nv);
		if (pushes > 0) cmp("vector", v, got);
	endtask : watch

	initial begin
		#300000;
		failures++;
		give_verdict();
	end
	initial begin
		tick(8);
		aresetn <= 1'h1;
		wait_rst();
		cmp_near("clock hold", STAB, hd_len);
		cmp_near("pin drive", STAB + 32, oe_len);
		cmp_near("cpu hold", STAB + 64, rs_len);
		cmp("reset vector", 32'hfffe, {16'h0, reset_vec});
		cmp("bus clock div4", 32'h1, {31'h0, bus_clk_div4});
		chk("cause after power-on", 8'h00, 32'h82);
		chk("cause after read", 8'h00, 32'h0);
		wr(8'h00, 32'hff, r);
		cmp("cause write resp", 32'h0, {30'h0, r});
		chk("cause after write", 8'h00, 32'h0);
		chk("status", 8'h08, 32'h221);
		rd(8'h0c, dd, r);
		cmp("unmapped resp", 32'h2, {30'h0, r});
		cmp("unmapped data", 32'h0, dd);
		base = rises;
		cpu_unmapped <= 1'h1;
		tick(600);
		cpu_unmapped <= 1'h0;
		cmp("resets while kicked", base, rises);
		fetch(1'h1, 1'h0, 1'h0);
		wait_rst();
		cmp_near("internal pin drive", 32, oe_len);
		cmp_near("internal cpu hold", 64, rs_len);
		cmp("pin drive level", 32'h0, {31'h0, rst_pin_out});
		fetch(1'h0, 1'h0, 1'h1);
		wait_rst();
		chk("opcode and address", 8'h00, 32'h18);
		fetch(1'h0, 1'h1, 1'h0);
		wait_rst();
		chk("halt refused", 8'h00, 32'h10);
		wr(8'h04, 32'h3, r);
		chk("ctrl", 8'h04, 32'h3);
		cmp("fast bus clock", 32'h0, {31'h0, bus_clk_div4});
		base = rises;
		fetch(1'h0, 1'h1, 1'h0);
		tick(20);
		cmp("halt permitted", base, rises);
		@(posedge aclk) monitor_force <= 1'h1;
		@(posedge aclk) monitor_force <= 1'h0;
		wait_rst();
		cmp("div4 after reset", 32'h1, {31'h0, bus_clk_div4});
		chk("monitor entry", 8'h00, 32'h04);
		wr(8'h04, 32'h0, r);
		lag <= 8'd40;
		@(posedge aclk) monitor_force <= 1'h1;
		@(posedge aclk) monitor_force <= 1'h0;
		wait_rst();
		tick(200);
		wait_rst();
		lag <= 8'd0;
		chk("slow pin release", 8'h00, 32'h44);
		// writes to any other location must leave the watchdog running
		cpu_addr <= 16'hfffe;
		wait_rst();
		cpu_addr <= 16'hffff;
		chk("watchdog", 8'h00, 32'h20);
		base = rises;
		ext_low <= 1'h1;
		tick(5);
		ext_low <= 1'h0;
		tick(40);
		cmp("short pin pulse", base, rises);
		ext_low <= 1'h1;
		tick(30);
		ext_low <= 1'h0;
		wait_rst();
		chk("external", 8'h00, 32'h40);
		low_supply <= 1'h1;
		tick(40);
		low_supply <= 1'h0;
		wait_rst();
		// clocks stay held through the 40-cycle low spell, then the stabilisation
		cmp_near("supply clock hold", 40 + STAB, hd_len);
		cmp_near("supply pin drive", 40 + STAB + 32, oe_len);
		chk("low supply", 8'h00, 32'h02);
		@(posedge aclk) monitor_force <= 1'h1;
		@(posedge aclk) monitor_force <= 1'h0;
		wait_rst();
		// four synced cycles of power-on restart the hold, so it runs three longer
		por_req <= 1'h1;
		tick(4);
		por_req <= 1'h0;
		wait_rst();
		cmp_near("power-on clock hold", STAB + 3, hd_len);
		chk("power-on clears others", 8'h00, 32'h82);
		@(posedge aclk) cpu_cli <= 1'h1;
		@(posedge aclk) cpu_cli <= 1'h0;
		irq_req <= 20'h5;
		tick(10);
		cmp("busy before insn end", 32'h0, {31'h0, int_busy});
		insn(1'h0);
		watch(1'h1, 16'hfffa, 0, 5);
		cmp("mask after entry", 32'h1, {31'h0, imask});
		ret();
		watch(1'h0, 16'hfffa, 5, 5);
		irq_req <= 20'h4;
		insn(1'h0);
		watch(1'h0, 16'h0, 0, 0);
		insn(1'h1);
		watch(1'h0, 16'hfffc, 0, 5);
		ret();
		watch(1'h0, 16'hfff6, 5, 5);
		irq_req <= 20'h0;
		ret();
		watch(1'h0, 16'h0, 5, 0);
		cmp("mask after return", 32'h0, {31'h0, imask});
		give_verdict();
	end
endmodule : tb
`default_nettype wire
